// file: hbpid_map.svh
// Register offsets, field positions, reset values and timing constants
`ifndef HBPID_MAP_SVH
`define HBPID_MAP_SVH

// Register byte offsets
`define HB_A_CTRL    8'h00
`define HB_A_OUT     8'h04
`define HB_A_RAMP    8'h08
`define HB_A_OVR     8'h0C
`define HB_A_CMD     8'h10
`define HB_A_TGT     8'h14
`define HB_A_FB      8'h18
`define HB_A_PTIME   8'h1C
`define HB_A_GKI     8'h20
`define HB_A_KDTD    8'h24
`define HB_A_TI      8'h28
`define HB_A_LEG     8'h2C
`define HB_A_STAT    8'h30
`define HB_A_PIDOUT  8'h34
`define HB_A_SIGNED  8'h38

// Control word fields
`define HB_C_BRIDGE  0
`define HB_C_PIDEN   1
`define HB_C_DIR     2
`define HB_C_OVRR    3
`define HB_C_TGTS    4
`define HB_C_FBS     5
`define HB_F_CSRC    6
`define HB_F_DSRC    8
`define HB_F_CRESP   10
`define HB_F_PRESP   12
`define HB_F_ENRESP  14

// Reset values
`define HB_RST_OUTMAX 16'h05DC
`define HB_RST_RAMP   16'h03E8
`define HB_RST_XMAX   16'h03E8
`define HB_RST_CYCLE  16'h000A
`define HB_RST_GAIN   16'h0100

// Scaling and timing
`define HB_PCT_FULL    16'h03E8
`define HB_RAMP_MIN_MS 16'h0064
`define HB_CYCLE_MIN   16'h0001
`define HB_CLK_NS      5
`define HB_MS_NS       1000000
`define HB_CYC_PER_MS  (`HB_MS_NS / `HB_CLK_NS)
`endif

// file: hbpid_pkg.sv
// Types and shared helpers for the bridge output and PID controller
package hbpid_pkg;
`include "hbpid_map.svh"

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        we;
    logic        re;
  } hbpid_bus_t;

  typedef struct packed {
    logic [15:0] g;
    logic [15:0] ki;
    logic [15:0] kd;
    logic [15:0] ti;
    logic [15:0] td;
    logic [15:0] cycle;
    logic [15:0] tol;
    logic [15:0] tgt_min;
    logic [15:0] tgt_max;
    logic [15:0] fb_min;
    logic [15:0] fb_max;
    logic [1:0]  resp;
    logic        tgt_sel;
    logic        fb_sel;
  } hbpid_pid_cfg_t;

  typedef struct packed {
    logic [15:0]        cnt;
    logic signed [16:0] prev;
    logic signed [31:0] sum;
    logic [15:0]        out;
  } hbpid_pid_st_t;

  typedef struct packed {
    logic [15:0]    ctrl;
    logic [15:0]    out_min;
    logic [15:0]    out_max;
    logic [15:0]    ramp_up;
    logic [15:0]    ramp_dn;
    logic [15:0]    ovr_val;
    logic [15:0]    cmd_lo;
    logic [15:0]    cmd_hi;
    logic [15:0]    leg0;
    logic [15:0]    leg1;
    hbpid_pid_cfg_t pid;
    logic [31:0]    ms_cnt;
    logic           tick;
    logic [3:0]     s1;
    logic [3:0]     s2;
    logic [31:0]    mag_q;
    logic           dir;
    logic [15:0]    leg_f;
    logic [15:0]    leg_r;
    logic [31:0]    rd;
  } hbpid_br_st_t;

  // Source value to 0..full percent of its own range
  function automatic logic [15:0] hbpid_pct(input logic [15:0] x,
                                            input logic [15:0] lo,
                                            input logic [15:0] hi);
    logic [31:0] q;
    q = 32'h0000_0000;
    if (hi <= lo || x <= lo) begin
      return 16'h0000;
    end
    if (x >= hi) begin
      return `HB_PCT_FULL;
    end
    q = (32'(x - lo) * 32'(`HB_PCT_FULL)) / 32'(hi - lo);
    return q[15:0];
  endfunction

endpackage

// file: hbpid_ctrl.sv
// Discrete PID controller producing a 0..full percent command
`timescale 1ns/10ps
`default_nettype none
`include "hbpid_map.svh"
module hbpid_ctrl (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     sys_rst,
  // Millisecond tick and enable
  input  wire logic                     tick,
  input  wire logic                     en,
  // Configuration and sources
  input  wire hbpid_pkg::hbpid_pid_cfg_t cfg,
  input  wire logic [15:0]              src_a,
  input  wire logic [15:0]              src_b,
  // Command
  output logic [15:0]                   pid_out
);
  import hbpid_pkg::*;

  hbpid_pid_st_t      st_reg;
  hbpid_pid_st_t      st_next;
  logic [15:0]        tp;
  logic [15:0]        fp;
  logic signed [16:0] e_raw;
  logic [16:0]        e_abs;
  logic signed [16:0] e;
  logic signed [16:0] de;
  logic signed [31:0] sum_n;
  logic [47:0]        ig_w;
  logic [47:0]        dg_w;
  logic [31:0]        ig;
  logic [31:0]        dg;
  logic signed [65:0] acc;
  logic signed [65:0] res;

  function automatic logic [15:0] clamp_pct(input logic signed [65:0] v);
    if (v < 0) begin
      return 16'h0000;
    end
    if (v > 66'(`HB_PCT_FULL)) begin
      return `HB_PCT_FULL;
    end
    return v[15:0];
  endfunction

  // Both ends in percent so units need not match
  assign tp = hbpid_pct(cfg.tgt_sel ? src_b : src_a,
                        cfg.tgt_min, cfg.tgt_max);
  assign fp = hbpid_pct(cfg.fb_sel ? src_b : src_a,
                        cfg.fb_min, cfg.fb_max);
  assign e_raw = $signed({1'b0, tp}) - $signed({1'b0, fp});
  assign e_abs = e_raw[16] ? 17'(-e_raw) : e_raw;
  assign e = (e_abs < 17'(cfg.tol)) ? 17'sd0 : e_raw;
  assign de = e - st_reg.prev;
  assign sum_n = st_reg.sum + 32'(e);
  // Gains in 8.8 fixed point; cycle and times all in ms
  assign ig_w = (cfg.ti == 16'h0000) ? 48'h0000_0000_0000 :
                (48'(cfg.g * cfg.ki) * 48'(cfg.cycle))
                / 48'(cfg.ti);
  assign dg_w = (48'(cfg.g * cfg.kd) * 48'(cfg.td))
                / 48'(cfg.cycle);
  assign ig = 32'(ig_w >> 8);
  assign dg = 32'(dg_w >> 8);
  assign acc = 66'($signed({1'b0, cfg.g}) * e)
             + 66'($signed({1'b0, ig}) * sum_n)
             + 66'($signed({1'b0, dg}) * de);
  assign res = acc >>> 8;

  always_comb begin
    st_next = st_reg;
    if (!en) begin
      st_next = '0;
    end else if (tick) begin
      st_next.cnt = st_reg.cnt + 16'h0001;
      if (st_next.cnt >= cfg.cycle) begin
        st_next.cnt = 16'h0000;
        st_next.prev = e;
        st_next.sum = sum_n;
        case (cfg.resp)
          2'd0: st_next.out = clamp_pct(res);
          2'd1: st_next.out = clamp_pct(res + 66'(tp));
          2'd2: st_next.out = (fp > tp) ? `HB_PCT_FULL : 16'h0000;
          2'd3: st_next.out = (fp < tp) ? `HB_PCT_FULL : 16'h0000;
          default: st_next.out = 16'h0000;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pid_out = st_reg.out;
endmodule
`default_nettype wire

// file: hbpid_bridge.sv
// Bipolar bridge output: command map, ramp, direction and leg drive
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "hbpid_map.svh"
module hbpid_bridge #(
  parameter int CYC_PER_MS = `HB_CYC_PER_MS
) (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  // Register port
  input  wire hbpid_pkg::hbpid_bus_t bus,
  output logic [31:0]               rd_data,
  // Asynchronous pins
  input  wire logic                 dir_pin,
  input  wire logic                 enable_pin,
  input  wire logic                 override_pin,
  input  wire logic                 fault_pin,
  // Control command and PID sources
  input  wire logic [15:0]          cmd_in,
  input  wire logic [15:0]          src_a,
  input  wire logic [15:0]          src_b,
  // Leg current commands in mA
  output logic [15:0]               leg_fwd_ma,
  output logic [15:0]               leg_rev_ma
);
  import hbpid_pkg::*;

  hbpid_br_st_t       st_reg;
  hbpid_br_st_t       st_next;
  logic               bridge;
  logic [1:0]         csrc;
  logic [1:0]         dsrc;
  logic [1:0]         cresp;
  logic [1:0]         enresp;
  logic [3:0]         pin_s;
  logic               dir_s;
  logic               en_s;
  logic               ovr_s;
  logic               flt_s;
  logic               want_dir;
  logic               en_on;
  logic               ovr_on;
  logic               shut_en;
  logic               kill;
  logic [15:0]        pid_out;
  logic [15:0]        x;
  logic [15:0]        xc;
  logic               below;
  logic               above;
  logic               resp_off;
  logic signed [17:0] dy;
  logic signed [16:0] dx;
  logic signed [35:0] prod;
  logic signed [35:0] quo;
  logic [15:0]        ymap;
  logic [15:0]        tgt_mag;
  logic [15:0]        range;
  logic [31:0]        up_q;
  logic [31:0]        dn_q;
  logic [32:0]        tgt_q;
  logic [32:0]        mag_up;
  logic [32:0]        mag_dn;
  logic [15:0]        mag;
  logic [31:0]        signed_ma;
  logic [31:0]        wd;

  function automatic logic [15:0] ramp_clamp(input logic [15:0] v);
    return (v < `HB_RAMP_MIN_MS) ? `HB_RAMP_MIN_MS : v;
  endfunction

  // Two-flop synchronisers: only the second stage is ever read
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      assign pin_s[gi] = st_reg.s2[gi];
    end
  endgenerate

  assign dir_s = pin_s[0];
  assign en_s = pin_s[1];
  assign ovr_s = pin_s[2];
  assign flt_s = pin_s[3];

  assign bridge = st_reg.ctrl[`HB_C_BRIDGE];
  assign csrc = st_reg.ctrl[`HB_F_CSRC +: 2];
  assign dsrc = st_reg.ctrl[`HB_F_DSRC +: 2];
  assign cresp = st_reg.ctrl[`HB_F_CRESP +: 2];
  assign enresp = st_reg.ctrl[`HB_F_ENRESP +: 2];
  assign mag = st_reg.mag_q[31:16];
  assign wd = bus.wdata;

  // Direction from the pin or from the control word
  assign want_dir = (dsrc == 2'd1) ? dir_s : st_reg.ctrl[`HB_C_DIR];

  // Enable response bit 0 inverts, bit 1 selects abrupt shutoff
  assign en_on = enresp[0] ? !en_s : en_s;
  assign shut_en = enresp[1] & !en_on;
  assign ovr_on = st_reg.ctrl[`HB_C_OVRR] ? !ovr_s : ovr_s;

  // Fault and missing sources stop at once, no ramp
  assign kill = flt_s | !bridge | (csrc == 2'd0) | (dsrc == 2'd0)
              | shut_en;

  assign x = (csrc == 2'd2) ? pid_out : cmd_in;
  assign below = x < st_reg.cmd_lo;
  assign above = x > st_reg.cmd_hi;
  assign xc = below ? st_reg.cmd_lo : (above ? st_reg.cmd_hi : x);
  assign resp_off = ((cresp == 2'd1) & below)
                  | ((cresp == 2'd2) & above);

  // Signed slope allows min above max for inverse response
  assign dy = $signed({2'b00, st_reg.out_max})
            - $signed({2'b00, st_reg.out_min});
  assign dx = $signed({1'b0, st_reg.cmd_hi})
            - $signed({1'b0, st_reg.cmd_lo});
  assign prod = 36'(dy * $signed({1'b0, 16'(xc - st_reg.cmd_lo)}));
  assign quo = (dx > 17'sd0) ? prod / 36'(dx) : 36'sd0;
  assign ymap = st_reg.out_min + quo[15:0];

  // Priority below enable, then override, then control
  always_comb begin
    if (!en_on) begin
      tgt_mag = 16'h0000;
    end else if (ovr_on) begin
      tgt_mag = st_reg.ovr_val;
    end else if (resp_off) begin
      tgt_mag = 16'h0000;
    end else begin
      tgt_mag = ymap;
    end
  end

  // Per-ms steps in 16.16 so slow ramps keep their exact duration
  assign range = (st_reg.out_max >= st_reg.out_min)
               ? st_reg.out_max - st_reg.out_min
               : st_reg.out_min - st_reg.out_max;
  assign up_q = {range, 16'h0000} / 32'(st_reg.ramp_up);
  assign dn_q = {range, 16'h0000} / 32'(st_reg.ramp_dn);
  assign tgt_q = {1'b0, tgt_mag, 16'h0000};
  assign mag_up = {1'b0, st_reg.mag_q} + {1'b0, (up_q == 32'h0000_0000)
                ? 32'h0000_0001 : up_q};
  assign mag_dn = {1'b0, st_reg.mag_q} - {1'b0, (dn_q == 32'h0000_0000)
                ? 32'h0000_0001 : dn_q};

  assign signed_ma = st_reg.dir ? 32'(-$signed({16'h0000, mag}))
                   : {16'h0000, mag};

  hbpid_ctrl u_pid (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .tick     (st_reg.tick),
    .en       (st_reg.ctrl[`HB_C_PIDEN]),
    .cfg      (st_reg.pid),
    .src_a    (src_a),
    .src_b    (src_b),
    .pid_out  (pid_out)
  );

  always_comb begin
    st_next = st_reg;
    st_next.rd = 32'h0000_0000;
    st_next.s1 = {fault_pin, override_pin, enable_pin, dir_pin};
    st_next.s2 = st_reg.s1;

    // Millisecond time base
    st_next.tick = 1'b0;
    if (st_reg.ms_cnt >= 32'(CYC_PER_MS - 1)) begin
      st_next.ms_cnt = 32'h0000_0000;
      st_next.tick = 1'b1;
    end else begin
      st_next.ms_cnt = st_reg.ms_cnt + 32'h0000_0001;
    end

    // Register writes
    if (bus.we) begin
      case (bus.addr)
        `HB_A_CTRL: begin
          st_next.ctrl = wd[15:0];
          st_next.pid.resp = wd[`HB_F_PRESP +: 2];
          st_next.pid.tgt_sel = wd[`HB_C_TGTS];
          st_next.pid.fb_sel = wd[`HB_C_FBS];
        end
        `HB_A_OUT: begin
          st_next.out_min = wd[15:0];
          st_next.out_max = wd[31:16];
        end
        `HB_A_RAMP: begin
          st_next.ramp_up = ramp_clamp(wd[15:0]);
          st_next.ramp_dn = ramp_clamp(wd[31:16]);
        end
        `HB_A_OVR: st_next.ovr_val = wd[15:0];
        `HB_A_CMD: begin
          st_next.cmd_lo = wd[15:0];
          st_next.cmd_hi = wd[31:16];
        end
        `HB_A_TGT: begin
          st_next.pid.tgt_min = wd[15:0];
          st_next.pid.tgt_max = wd[31:16];
        end
        `HB_A_FB: begin
          st_next.pid.fb_min = wd[15:0];
          st_next.pid.fb_max = wd[31:16];
        end
        `HB_A_PTIME: begin
          // Zero period would divide by zero in the derivative gain
          st_next.pid.cycle = (wd[15:0] < `HB_CYCLE_MIN)
                            ? `HB_CYCLE_MIN : wd[15:0];
          st_next.pid.tol = wd[31:16];
        end
        `HB_A_GKI: begin
          st_next.pid.g = wd[15:0];
          st_next.pid.ki = wd[31:16];
        end
        `HB_A_KDTD: begin
          st_next.pid.kd = wd[15:0];
          st_next.pid.td = wd[31:16];
        end
        `HB_A_TI: st_next.pid.ti = wd[15:0];
        `HB_A_LEG: begin
          if (!bridge) begin
            st_next.leg0 = wd[15:0];
            st_next.leg1 = wd[31:16];
          end
        end
        default: begin
        end
      endcase
    end

    // Register reads, data valid only in the following cycle
    if (bus.re) begin
      case (bus.addr)
        `HB_A_CTRL: st_next.rd = {16'h0000, st_reg.ctrl};
        `HB_A_OUT: st_next.rd = {st_reg.out_max, st_reg.out_min};
        `HB_A_RAMP: st_next.rd = {st_reg.ramp_dn, st_reg.ramp_up};
        `HB_A_OVR: st_next.rd = {16'h0000, st_reg.ovr_val};
        `HB_A_CMD: st_next.rd = {st_reg.cmd_hi, st_reg.cmd_lo};
        `HB_A_TGT: st_next.rd = {st_reg.pid.tgt_max, st_reg.pid.tgt_min};
        `HB_A_FB: st_next.rd = {st_reg.pid.fb_max, st_reg.pid.fb_min};
        `HB_A_PTIME: st_next.rd = {st_reg.pid.tol, st_reg.pid.cycle};
        `HB_A_GKI: st_next.rd = {st_reg.pid.ki, st_reg.pid.g};
        `HB_A_KDTD: st_next.rd = {st_reg.pid.td, st_reg.pid.kd};
        `HB_A_TI: st_next.rd = {16'h0000, st_reg.pid.ti};
        `HB_A_LEG: st_next.rd = {st_reg.leg1, st_reg.leg0};
        `HB_A_STAT: st_next.rd = {14'h0000, !kill, st_reg.dir, mag};
        `HB_A_PIDOUT: st_next.rd = {16'h0000, pid_out};
        `HB_A_SIGNED: st_next.rd = signed_ma;
        default: st_next.rd = 32'h0000_0000;
      endcase
    end

    // Magnitude ramp and direction handling
    if (kill) begin
      st_next.mag_q = 32'h0000_0000;
      st_next.dir = want_dir;
    end else if (want_dir != st_reg.dir) begin
      st_next.mag_q = 32'h0000_0000;
      st_next.dir = want_dir;
    end else if (st_reg.tick) begin
      if ({1'b0, st_reg.mag_q} < tgt_q) begin
        st_next.mag_q = (mag_up >= tgt_q) ? tgt_q[31:0]
                      : mag_up[31:0];
      end else if ({1'b0, st_reg.mag_q} > tgt_q) begin
        st_next.mag_q = (mag_dn[32] || mag_dn <= tgt_q) ? tgt_q[31:0]
                      : mag_dn[31:0];
      end
    end

    // Legs: bridge owns both, else the individual settings
    if (bridge) begin
      st_next.leg_f = st_reg.dir ? 16'h0000 : mag;
      st_next.leg_r = st_reg.dir ? mag : 16'h0000;
    end else begin
      st_next.leg_f = st_reg.leg0;
      st_next.leg_r = st_reg.leg1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_reg <= '0;
      st_reg.out_max <= `HB_RST_OUTMAX;
      st_reg.ramp_up <= `HB_RST_RAMP;
      st_reg.ramp_dn <= `HB_RST_RAMP;
      st_reg.cmd_hi <= `HB_RST_XMAX;
      st_reg.pid.tgt_max <= `HB_RST_XMAX;
      st_reg.pid.fb_max <= `HB_RST_XMAX;
      st_reg.pid.cycle <= `HB_RST_CYCLE;
      st_reg.pid.g <= `HB_RST_GAIN;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data = st_reg.rd;
  assign leg_fwd_ma = st_reg.leg_f;
  assign leg_rev_ma = st_reg.leg_r;
endmodule
`default_nettype wire

// file: hbpid_coil.sv
// Load coil model seen across the two bridge legs
`timescale 1ns/10ps
`default_nettype none
module hbpid_coil (
  // Leg current commands
  input  wire logic [15:0]   leg_fwd_ma,
  input  wire logic [15:0]   leg_rev_ma,
  // Signed coil current and shoot-through flag
  output logic signed [17:0] coil_ma,
  output logic               shoot_thru
);
  // Forward leg pushes current, backward leg pulls it
  assign coil_ma = $signed({2'b00, leg_fwd_ma})
                 - $signed({2'b00, leg_rev_ma});
  // Both legs on would short the supply through the coil
  assign shoot_thru = leg_fwd_ma != 16'h0000 && leg_rev_ma != 16'h0000;
endmodule
`default_nettype wire

// file: hbpid_bridge_sva.sv
// Port checker for the bridge output block
`timescale 1ns/10ps
`default_nettype none
module hbpid_bridge_sva #(
  parameter int CYC_PER_MS = 10
) (
  // Clock, reset and register port
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  input  wire hbpid_pkg::hbpid_bus_t bus,
  input  wire logic [31:0]           rd_data,
  // Pins and legs
  input  wire logic                  fault_pin,
  input  wire logic [15:0]           leg_fwd_ma,
  input  wire logic [15:0]           leg_rev_ma
);
  logic [15:0] ctrl_sh_reg;
  logic [31:0] leg_sh_reg;
  logic [1:0]  on_hist_reg;
  logic        br_on;
  logic        br_ok;
  logic        off_src;
  assign br_on = ctrl_sh_reg[0];
  // Legs lag the control word by one edge; the check waits for two
  assign br_ok = br_on && on_hist_reg == 2'b11;
  assign off_src = ctrl_sh_reg[7:6] == 2'h0 || ctrl_sh_reg[9:8] == 2'h0;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_sh_reg <= 16'h0000;
      leg_sh_reg  <= 32'h0000_0000;
      on_hist_reg <= 2'b00;
    end else begin
      on_hist_reg <= {on_hist_reg[0], br_on};
      if (bus.we && bus.addr == 8'h00) ctrl_sh_reg <= bus.wdata[15:0];
      if (bus.we && bus.addr == 8'h2C && !br_on) leg_sh_reg <= bus.wdata;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  legs_exclusive_a: assert property (br_ok |-> leg_fwd_ma == 16'h0000 || leg_rev_ma == 16'h0000)
    else $error("both legs driven");
  dir_zero_a: assert property (br_ok && $past(leg_fwd_ma) != 16'h0000 |-> leg_rev_ma == 16'h0000)
    else $error("reversal skipped zero");
  fault_kill_a: assert property ((br_ok && fault_pin)[*6] |-> leg_fwd_ma == 16'h0000 && leg_rev_ma == 16'h0000)
    else $error("fault left legs on");
  src_none_a: assert property ((br_ok && off_src)[*6] |-> leg_fwd_ma == 16'h0000 && leg_rev_ma == 16'h0000)
    else $error("no source left legs on");
  leg_lock_a: assert property ((!br_on && !bus.we)[*4] |-> {leg_rev_ma, leg_fwd_ma} == leg_sh_reg)
    else $error("leg setting not held");
  ramp_clamp_a: assert property (bus.re && bus.addr == 8'h08 |=> rd_data[15:0] >= 16'h0064 && rd_data[31:16] >= 16'h0064)
    else $error("ramp time below floor");
  pid_range_a: assert property (bus.re && bus.addr == 8'h34 && ctrl_sh_reg[13:12] == 2'h0 |=> rd_data <= 32'h0000_03E8)
    else $error("pid output above full");
  ramp_pace_a: assert property (br_ok && leg_fwd_ma > $past(leg_fwd_ma) |=> (leg_fwd_ma <= $past(leg_fwd_ma))[*8])
    else $error("ramp rose between ticks");
  cover property (br_ok && leg_rev_ma != 16'h0000);
  cover property (br_ok && fault_pin);
  cover property (bus.re && bus.addr == 8'h34);
endmodule
bind hbpid_bridge hbpid_bridge_sva #(.CYC_PER_MS(CYC_PER_MS)) u_sva (
  .core_clk(core_clk), .sys_rst(sys_rst), .bus(bus), .rd_data(rd_data),
  .fault_pin(fault_pin), .leg_fwd_ma(leg_fwd_ma), .leg_rev_ma(leg_rev_ma)
);
`default_nettype wire

// file: test_hbpid_bridge.sv
// Self-checking bench for the bridge output and PID block
`timescale 1ns/10ps
`default_nettype none
module test_hbpid_bridge;
  import hbpid_pkg::*;
  logic               core_clk;
  logic               sys_rst;
  hbpid_bus_t         bus;
  logic [31:0]        rd_data;
  logic               dir_pin;
  logic               enable_pin;
  logic               override_pin;
  logic               fault_pin;
  logic [15:0]        cmd_in;
  logic [15:0]        src_a;
  logic [15:0]        src_b;
  logic [15:0]        leg_fwd_ma;
  logic [15:0]        leg_rev_ma;
  logic signed [17:0] coil_ma;
  logic               shoot_thru;
  int                 errors;
  int                 checks;
  logic [31:0]        rv;
  logic [39:0] rst_tab [9] = '{40'h00_0000_0000, 40'h04_05DC_0000,
    40'h08_03E8_03E8, 40'h10_03E8_0000, 40'h14_03E8_0000, 40'h18_03E8_0000,
    40'h1C_0000_000A, 40'h20_0000_0100, 40'h3C_0000_0000};
  // Response code, command, expected backward leg
  logic [47:0] cr_tab [4] = '{48'h0000_0064_0064, 48'h0001_0064_0000,
    48'h0002_0384_0000, 48'h0000_0384_03E8};

  hbpid_bridge #(.CYC_PER_MS(10)) u_dut (.core_clk(core_clk),
    .sys_rst(sys_rst), .bus(bus), .rd_data(rd_data), .dir_pin(dir_pin),
    .enable_pin(enable_pin), .override_pin(override_pin),
    .fault_pin(fault_pin), .cmd_in(cmd_in), .src_a(src_a), .src_b(src_b),
    .leg_fwd_ma(leg_fwd_ma), .leg_rev_ma(leg_rev_ma));
  hbpid_coil u_coil (.leg_fwd_ma(leg_fwd_ma), .leg_rev_ma(leg_rev_ma),
    .coil_ma(coil_ma), .shoot_thru(shoot_thru));

  always #2.5 core_clk = ~core_clk;

  task automatic check(input string w, input logic [31:0] s,
                       input logic [31:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge core_clk);
    bus.we <= 1'b0;
  endtask
  // Read data is only valid in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: 32'h0000_0000, we: 1'b0, re: 1'b1};
    @(posedge core_clk);
    bus.re <= 1'b0;
    #1 d = rd_data;
  endtask
  task automatic rdc(input string w, input logic [7:0] a,
                     input logic [31:0] e);
    rd(a, rv);
    check(w, rv, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic finish_test;
    if (errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Whole sequence needs about 12000 cycles
  initial begin
    #400000;
    errors++;
    finish_test;
  end

  initial begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    bus = '0;
    dir_pin = 1'b0;
    enable_pin = 1'b1;
    override_pin = 1'b0;
    fault_pin = 1'b0;
    cmd_in = 16'h0000;
    src_a = 16'h0000;
    src_b = 16'h0000;
    errors = 0;
    checks = 0;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    foreach (rst_tab[k]) rdc("reset", rst_tab[k][39:32], rst_tab[k][31:0]);
    wr(8'h2C, 32'h0007_0005);
    cyc(4);
    check("legs off", {leg_rev_ma, leg_fwd_ma}, 32'h0007_0005);
    wr(8'h00, 32'h0000_0241);
    wr(8'h2C, 32'h0009_0009);
    rdc("leg lock", 8'h2C, 32'h0007_0005);
    wr(8'h20, 32'h0000_0200);
    rdc("gain edit", 8'h20, 32'h0000_0200);
    wr(8'h20, 32'h0000_0100);
    wr(8'h08, 32'h0032_0010);
    rdc("ramp floor", 8'h08, 32'h0064_0064);
    wr(8'h04, 32'h03E8_0000);
    cmd_in <= 16'h03E8;
    cyc(500);
    check("half ramp", 32'(leg_fwd_ma >= 16'h01CC && leg_fwd_ma <= 16'h0208), 32'h1);
    cyc(600);
    check("full fwd", 32'(leg_fwd_ma), 32'h0000_03E8);
    check("rev off", 32'(leg_rev_ma), 32'h0);
    check("no shoot", 32'(shoot_thru), 32'h0);
    @(posedge core_clk) cmd_in <= 16'h01F4;
    cyc(300);
    check("part down", 32'(leg_fwd_ma >= 16'h02A8 && leg_fwd_ma <= 16'h02D0), 32'h1);
    cyc(300);
    check("down end", 32'(leg_fwd_ma), 32'h0000_01F4);
    wr(8'h00, 32'h0000_0245);
    cyc(4);
    check("flip zero", 32'(leg_fwd_ma), 32'h0);
    check("flip start", 32'(coil_ma >= -18'sd20), 32'h1);
    cyc(700);
    check("rev coil", 32'(coil_ma), 32'hFFFF_FE0C);
    rdc("status", 8'h30, 32'h0003_01F4);
    wr(8'h0C, 32'h0000_012C);
    override_pin <= 1'b1;
    cyc(400);
    check("override", 32'(coil_ma), 32'hFFFF_FED4);
    @(posedge core_clk) override_pin <= 1'b0;
    wr(8'h10, 32'h0320_00C8);
    wr(8'h04, 32'h03E8_0064);
    foreach (cr_tab[k]) begin
      @(posedge core_clk) cmd_in <= cr_tab[k][31:16];
      wr(8'h00, 32'h0000_0245 | (32'(cr_tab[k][47:32]) << 10));
      cyc(1300);
      check("response", 32'(leg_rev_ma), 32'(cr_tab[k][15:0]));
    end
    wr(8'h00, 32'h0000_0205);
    cyc(10);
    check("no source", {leg_rev_ma, leg_fwd_ma}, 32'h0);
    wr(8'h00, 32'h0000_0245);
    cyc(200);
    @(posedge core_clk) fault_pin <= 1'b1;
    cyc(6);
    check("fault", {leg_rev_ma, leg_fwd_ma}, 32'h0);
    @(posedge core_clk) enable_pin <= 1'b0;
    @(posedge core_clk) fault_pin <= 1'b0;
    cyc(200);
    check("enable off", {leg_rev_ma, leg_fwd_ma}, 32'h0);
    @(posedge core_clk) enable_pin <= 1'b1;
    wr(8'h04, 32'h03E8_0000);
    wr(8'h10, 32'h03E8_0000);
    src_a <= 16'h03E8;
    wr(8'h00, 32'h0000_02A3);
    cyc(300);
    rdc("pid full", 8'h34, 32'h0000_03E8);
    @(posedge core_clk) src_a <= 16'h01F4;
    cyc(300);
    rdc("pid half", 8'h34, 32'h0000_01F4);
    cyc(1200);
    check("pid leg", 32'(leg_fwd_ma), 32'h0000_01F4);
    wr(8'h28, 32'h0000_000A);
    wr(8'h20, 32'h0100_0100);
    cyc(300);
    rdc("pid integ", 8'h34, 32'h0000_03E8);
    wr(8'h20, 32'h0000_0100);
    wr(8'h1C, 32'h0258_000A);
    cyc(300);
    rdc("tolerance", 8'h34, 32'h0);
    wr(8'h1C, 32'h0000_000A);
    wr(8'h00, 32'h0000_12A3);
    cyc(300);
    rdc("setpoint", 8'h34, 32'h0000_03E8);
    wr(8'h00, 32'h0000_22A3);
    cyc(300);
    rdc("over", 8'h34, 32'h0);
    wr(8'h00, 32'h0000_32A3);
    cyc(300);
    rd(8'h34, rv);
    check("below", rv, 32'h0000_03E8);
    finish_test;
  end
endmodule
`default_nettype wire
